// ==== logic/cks_pkg.sv ====
// Package for the system clock switch: register layout, modes, timing.
// Assumes a single 20 MHz bus clock; oscillators are modelled as clock pins, with a ready input for the secondary only.
package cks_pkg;

  // Register byte offsets
  localparam logic [11:0] OSC_CTRL_OFS   = 12'h000;
  localparam logic [11:0] OSC_STAT_OFS   = 12'h004;
  localparam logic [11:0] TMR1_CTRL_OFS  = 12'h008;
  localparam logic [11:0] ACTIVE_SRC_OFS = 12'h00C;

  // Control register fields
  localparam int SCS_LSB  = 0;
  localparam int IRCF_LSB = 3;
  localparam logic [3:0] IRCF_RESET = 4'h7;
  localparam logic [1:0] SCS_RESET  = 2'h0;

  // Status register bit positions
  localparam int SECONDARY_OSC_READY_FLAG_BIT = 7;
  localparam int STARTUP_TIMER_STATUS_FLAG_BIT  = 5;
  localparam int HFR_BIT   = 4;
  localparam int MFR_BIT   = 2;
  localparam int LFR_BIT   = 1;

  localparam int T1OSC_BIT = 3;

  // Primary mode encodings
  localparam logic [2:0] MODE_LP = 3'h0;
  localparam logic [2:0] MODE_XT = 3'h1;
  localparam logic [2:0] MODE_HS = 3'h2;

  localparam int OST_COUNT = 1024;

  // Internal oscillator warm-up delay
  localparam int CLK_MHZ       = 20;
  localparam int WARM_NS       = 2000;
  localparam int WARM_CYCLES   = (WARM_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] { SRC_LF, SRC_MF, SRC_HF } cks_osc_t;
  typedef enum logic [1:0] { ACT_PRI, ACT_SEC, ACT_INT } cks_act_t;

  typedef struct packed {
    logic [3:0] ircf;
    logic [1:0] system_clock_select;
  } cks_ctrl_t;

endpackage

// ==== logic/cks_top.sv ====
// What this block does
// - Start powered-down oscillator, wait warm-up first
// - Wait falling edge of current clock
// - Hold low until new clock rises
// - Update status, then switch done
// - Status shows each internal oscillator active
// - Same source: switch without warm-up
// - Select field picks primary, secondary, internal
// - Reset clears system clock select
// - Automatic switches leave select untouched
// - Start-up flag set after count ends, or by power-up timer outside crystal
// - Secondary oscillator enabled by timer1 bit
// - Crystal modes count 1024 cycles first
// - Two-speed off outside crystal modes
// - Count done before sleep: flag, go external
// - Sleep aborts count, flag stays clear
// - Two-speed needs switchover bit, select 00, crystal
// - Start after power-up timer or wake
// - Run internal; switch on edges after timeout
// - Reset loads frequency select with 0111
//
// File holds the clock switch controller with its AHB-Lite register slave.
// Assumes oscillator clocks are sampled as pins by hclk; the gated output
// clock is modelled by a registered system clock level.
`timescale 1ns/1ns
module cks_top
  import cks_pkg::*;
#(
  parameter int OST_N  = OST_COUNT,
  parameter int WARM_N = WARM_CYCLES
) (
  input  wire logic        hclk,            // Bus clock
  input  wire logic        hresetn,         // Async reset, low
  input  wire logic        hsel,            // Slave select
  input  wire logic [31:0] haddr,           // Address
  input  wire logic [1:0]  htrans,          // Transfer type
  input  wire logic        hwrite,          // Write
  input  wire logic [2:0]  hsize,           // Size
  input  wire logic [31:0] hwdata,          // Write data
  input  wire logic        hready,          // Bus ready
  output logic      [31:0] hrdata,          // Read data
  output logic             hreadyout,       // Slave ready
  output logic             hresp,           // Response
  input  wire logic [2:0]  primary_mode,    // Primary mode config
  input  wire logic        switchover_cfg,  // Two-speed enable config
  input  wire logic        power_up_timer_done,       // Power-up timer expired
  input  wire logic        sleep_req,       // Sleep executed, pulse
  input  wire logic        wake,            // Wake from sleep, pulse
  input  wire logic        pri_clk_pin,     // Primary oscillator clock
  input  wire logic        sec_clk_pin,     // Secondary oscillator clock
  input  wire logic        int_clk_pin,     // Internal block clock
  input  wire logic        sec_ready_pin,   // Secondary oscillator ready
  output logic             sys_clk,         // Switched system clock level
  output logic             sec_osc_en,      // Secondary oscillator enable
  output logic [2:0]       osc_power_en,    // HF, MF, LF power enables
  output logic [1:0]       active_src       // Active source
);

  typedef enum logic [2:0] { SW_IDLE, SW_WARM, SW_FALL, SW_RISE, SW_DONE } cks_sw_t;

  cks_ctrl_t  ctrl_reg;
  logic       t1osc_reg;
  logic       startup_timer_status_flag_reg;
  logic [2:0] osc_on_reg;
  cks_osc_t   cur_osc_reg;
  cks_osc_t   tgt_osc_reg;
  cks_act_t   act_reg;
  cks_sw_t    sw_reg;
  logic [15:0] warm_cnt_reg;
  logic [15:0] ost_cnt_reg;
  logic       ost_run_reg;
  logic       ost_done_reg;
  logic       power_up_timer_seen_reg;
  logic [3:0] ircf_prev_reg;
  logic [1:0] scs_prev_reg;
  logic       ts_pending_reg;

  // Pin synchronisers
  logic [1:0] pri_s, sec_s, int_s, rdy_s;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pri_s <= 2'h0;
      sec_s <= 2'h0;
      int_s <= 2'h0;
      rdy_s <= 2'h0;
    end else begin
      pri_s <= {pri_s[0], pri_clk_pin};
      sec_s <= {sec_s[0], sec_clk_pin};
      int_s <= {int_s[0], int_clk_pin};
      rdy_s <= {rdy_s[0], sec_ready_pin};
    end
  end

  logic pri_d, int_d;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pri_d <= 1'b0;
      int_d <= 1'b0;
    end else begin
      pri_d <= pri_s[1];
      int_d <= int_s[1];
    end
  end
  wire pri_rise = pri_s[1] & ~pri_d;
  wire pri_fall = ~pri_s[1] & pri_d;
  wire int_rise = int_s[1] & ~int_d;
  wire int_fall = ~int_s[1] & int_d;

  function automatic cks_osc_t osc_of(input logic [3:0] f);
    if (f[3] || f == 4'h3) osc_of = SRC_HF;
    else if (f[3:1] == 3'h0) osc_of = SRC_LF;
    else osc_of = SRC_MF;
  endfunction

  wire crystal = (primary_mode == MODE_LP) || (primary_mode == MODE_XT) ||
                 (primary_mode == MODE_HS);
  wire ts_enable = switchover_cfg && (ctrl_reg.system_clock_select == 2'h0) && crystal;

  // AHB-Lite slave, zero wait
  logic        dp_wr, dp_rd;
  logic [11:0] dp_addr;
  wire         take = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_rd   <= 1'b0;
      dp_addr <= 12'h000;
    end else begin
      dp_wr   <= take && hwrite;
      dp_rd   <= take && !hwrite;
      dp_addr <= haddr[11:0];
    end
  end

  logic [7:0] stat_val;
  always_comb begin
    stat_val = 8'h00;
    stat_val[SECONDARY_OSC_READY_FLAG_BIT] = t1osc_reg ? rdy_s[1] : 1'b1;
    stat_val[STARTUP_TIMER_STATUS_FLAG_BIT]  = startup_timer_status_flag_reg;
    stat_val[HFR_BIT]   = osc_on_reg[SRC_HF];
    stat_val[MFR_BIT]   = osc_on_reg[SRC_MF];
    stat_val[LFR_BIT]   = osc_on_reg[SRC_LF];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      case (haddr[11:0])
        OSC_CTRL_OFS:   hrdata <= {25'h0, ctrl_reg.ircf, 1'b0, ctrl_reg.system_clock_select};
        OSC_STAT_OFS:   hrdata <= {24'h0, stat_val};
        TMR1_CTRL_OFS:  hrdata <= {28'h0, t1osc_reg, 3'h0};
        ACTIVE_SRC_OFS: hrdata <= {30'h0, act_reg};
        default:        hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Software writes; automatic switches never touch select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg.ircf <= IRCF_RESET;
      ctrl_reg.system_clock_select  <= SCS_RESET;
      t1osc_reg     <= 1'b0;
    end else if (dp_wr) begin
      case (dp_addr)
        OSC_CTRL_OFS: begin
          ctrl_reg.ircf <= hwdata[IRCF_LSB +: 4];
          ctrl_reg.system_clock_select  <= hwdata[SCS_LSB +: 2];
        end
        TMR1_CTRL_OFS: t1osc_reg <= hwdata[T1OSC_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sec_osc_en <= 1'b0;
    else sec_osc_en <= t1osc_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ircf_prev_reg <= IRCF_RESET;
      scs_prev_reg  <= SCS_RESET;
    end else begin
      // Keep a change pending until the sequencer is free to take it
      if (sw_reg == SW_IDLE) ircf_prev_reg <= ctrl_reg.ircf;
      scs_prev_reg  <= ctrl_reg.system_clock_select;
    end
  end
  wire ircf_chg = ctrl_reg.ircf != ircf_prev_reg;

  // Internal frequency switch sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_reg       <= SW_IDLE;
      cur_osc_reg  <= SRC_MF;
      tgt_osc_reg  <= SRC_MF;
      osc_on_reg   <= 3'h0;
      warm_cnt_reg <= 16'h0000;
    end else begin
      case (sw_reg)
        SW_IDLE: begin
          osc_on_reg <= 3'h0;
          osc_on_reg[cur_osc_reg] <= 1'b1;
          if (ircf_chg) begin
            tgt_osc_reg <= osc_of(ctrl_reg.ircf);
            if (osc_of(ctrl_reg.ircf) == cur_osc_reg) begin
              sw_reg <= SW_IDLE;
            end else if (!osc_on_reg[osc_of(ctrl_reg.ircf)]) begin
              warm_cnt_reg <= 16'h0000;
              sw_reg <= SW_WARM;
            end else begin
              sw_reg <= SW_FALL;
            end
          end
        end
        SW_WARM: begin
          warm_cnt_reg <= warm_cnt_reg + 16'h0001;
          if (warm_cnt_reg == 16'(WARM_N - 1)) sw_reg <= SW_FALL;
        end
        SW_FALL: if (int_fall) sw_reg <= SW_RISE;
        SW_RISE: if (int_rise) begin
          cur_osc_reg <= tgt_osc_reg;
          sw_reg <= SW_DONE;
        end
        SW_DONE: begin
          osc_on_reg <= 3'h0;
          osc_on_reg[cur_osc_reg] <= 1'b1;
          sw_reg <= SW_IDLE;
        end
        default: sw_reg <= SW_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) osc_power_en <= 3'h0;
    else begin
      osc_power_en <= 3'h0;
      osc_power_en[cur_osc_reg] <= 1'b1;
      if (sw_reg != SW_IDLE) osc_power_en[tgt_osc_reg] <= 1'b1;
    end
  end

  // Start-up timer and two-speed start-up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) power_up_timer_seen_reg <= 1'b0;
    else if (power_up_timer_done) power_up_timer_seen_reg <= 1'b1;
  end
  wire por_start = power_up_timer_done && !power_up_timer_seen_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ost_run_reg  <= 1'b0;
      ost_done_reg <= 1'b0;
      ost_cnt_reg  <= 16'h0000;
    end else if (sleep_req) begin
      ost_run_reg  <= 1'b0;
      ost_done_reg <= 1'b0;
      ost_cnt_reg  <= 16'h0000;
    end else if ((por_start || wake) && crystal) begin
      ost_run_reg  <= 1'b1;
      ost_done_reg <= 1'b0;
      ost_cnt_reg  <= 16'h0000;
    end else if (ost_run_reg && pri_rise) begin
      ost_cnt_reg <= ost_cnt_reg + 16'h0001;
      if (ost_cnt_reg == 16'(OST_N - 1)) begin
        ost_run_reg  <= 1'b0;
        ost_done_reg <= 1'b1;
      end
    end
  end

  // Switchover from internal to primary after timeout
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ts_pending_reg <= 1'b0;
      startup_timer_status_flag_reg       <= 1'b0;
    end else if (sleep_req || por_start || wake) begin
      ts_pending_reg <= 1'b0;
      startup_timer_status_flag_reg       <= crystal ? 1'b0 : power_up_timer_seen_reg | por_start;
    end else if (!crystal) begin
      startup_timer_status_flag_reg <= power_up_timer_seen_reg;
    end else if (ost_done_reg && !startup_timer_status_flag_reg && !ts_pending_reg && int_fall) begin
      ts_pending_reg <= 1'b1;
      startup_timer_status_flag_reg       <= 1'b1;
    end else if (ts_pending_reg && pri_fall) begin
      ts_pending_reg <= 1'b0;
    end
  end

  // Active source and glitch-free output
  cks_act_t act_want;
  always_comb begin
    if (ctrl_reg.system_clock_select[1]) act_want = ACT_INT;
    else if (ctrl_reg.system_clock_select == 2'h1) act_want = ACT_SEC;
    else if (ts_enable && (!startup_timer_status_flag_reg || ts_pending_reg)) act_want = ACT_INT;
    else act_want = ACT_PRI;
  end

  // Source only moves while the system clock is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) act_reg <= ACT_PRI;
    else if (!sys_clk) act_reg <= act_want;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) active_src <= 2'h0;
    else active_src <= act_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sys_clk <= 1'b0;
    else if (sw_reg == SW_RISE || ts_pending_reg) sys_clk <= 1'b0;
    else if ((act_want != act_reg) && !sys_clk) sys_clk <= 1'b0;
    else begin
      case (act_reg)
        ACT_PRI: sys_clk <= pri_s[1];
        ACT_SEC: sys_clk <= sec_s[1];
        default: sys_clk <= int_s[1];
      endcase
    end
  end

endmodule

// ==== dv/cks_top_checker.sv ====
// Port checker for the clock switch.
// Assumes a bind onto cks_top from the bench top.
`timescale 1ns/1ns
module cks_top_checker
  import cks_pkg::*;
(
  input wire logic        hclk,           // Clock
  input wire logic        hresetn,        // Reset, low
  input wire logic        hsel,           // Select
  input wire logic [31:0] haddr,          // Address
  input wire logic [1:0]  htrans,         // Transfer
  input wire logic        hwrite,         // Write
  input wire logic        hready,         // Ready in
  input wire logic [31:0] hrdata,         // Read data
  input wire logic        hreadyout,      // Ready out
  input wire logic        hresp,          // Response
  input wire logic [2:0]  primary_mode,   // Mode
  input wire logic        switchover_cfg, // Two-speed
  input wire logic        sleep_req,      // Sleep
  input wire logic        wake,           // Wake
  input wire logic        sys_clk,        // System clock
  input wire logic        sec_osc_en,     // Secondary enable
  input wire logic [2:0]  osc_power_en,   // Power enables
  input wire logic [1:0]  active_src      // Source
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic ap_rd;
  logic ap_t1;
  wire  take = hsel & htrans[1] & hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_rd <= 1'b0;
      ap_t1 <= 1'b0;
    end else begin
      ap_rd <= take & ~hwrite;
      ap_t1 <= take & hwrite & (haddr[11:0] == TMR1_CTRL_OFS);
    end
  end
  sequence s_src_move;
    $changed(active_src);
  endsequence
  sequence s_int_sleep;
    sleep_req && active_src == ACT_INT && switchover_cfg && primary_mode <= MODE_HS;
  endsequence
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  AST_RDATA: assert property ($changed(hrdata) |-> ap_rd)
    else $error("read data moved without a read");
  AST_SEC_EN: assert property ($changed(sec_osc_en) |-> $past(ap_t1, 2) || $past(ap_t1, 3))
    else $error("secondary enable moved without timer1 write");
  AST_LOW: assert property (s_src_move |-> !$past(sys_clk))
    else $error("source changed while clock high");
  AST_RUNT: assert property ($rose(sys_clk) |=> sys_clk)
    else $error("runt pulse on system clock");
  AST_PWR: assert property (active_src == ACT_INT |-> osc_power_en != 3'h0)
    else $error("internal source active with no oscillator on");
  AST_SLEEP: assert property (s_int_sleep |=> (active_src == ACT_INT) [*4])
    else $error("sleep did not abort start-up");
  AST_NOXTAL: assert property (wake && primary_mode > MODE_HS && active_src == ACT_PRI
                               |=> (active_src == ACT_PRI) [*3])
    else $error("two-speed ran outside crystal modes");
endmodule

// ==== dv/cks_osc_model.sv ====
// Oscillator sources beside the clock switch.
// Assumes a 1 ns time unit; the timekeeping crystal stands still when off.
`timescale 1ns/1ns
module cks_osc_model (
  input  wire logic sec_en,  // Secondary enable
  output logic      pri_clk, // Crystal clock
  output logic      sec_clk, // Timekeeping clock
  output logic      int_clk, // Internal block clock
  output logic      sec_rdy  // Secondary settled
);
  initial begin
    pri_clk = 1'b0;
    int_clk = 1'b0;
    sec_clk = 1'b0;
    sec_rdy = 1'b0;
  end
  always #200 pri_clk = ~pri_clk;
  always #150 int_clk = ~int_clk;
  always #500 sec_clk = sec_en ? ~sec_clk : 1'b0;
  // Ready only after a settling time
  always @(sec_en) begin
    sec_rdy = 1'b0;
    if (sec_en) #4000 sec_rdy = sec_en;
  end
endmodule

// ==== dv/test_cks_top.sv ====
// Bench for the clock switch: bus tasks and switching scenarios.
// Assumes the oscillator model and the checker in dv/.
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end
module test_cks_top
  import cks_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, sleep_req, wake;
  logic        switchover_cfg, power_up_timer_done, sys_clk, sec_osc_en, pri, sec, intc, srdy;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, active_src;
  logic [2:0]  primary_mode, osc_power_en;
  int          miscompares = 0;
  int          tests_run = 0;
  int          last_wait;
  logic [3:0]  fs[4] = '{4'h7, 4'h6, 4'hF, 4'h0};
  int          fb[4] = '{MFR_BIT, MFR_BIT, HFR_BIT, LFR_BIT};
  int          pb[4] = '{1, 1, 2, 0};
  cks_top #(.OST_N(8), .WARM_N(2)) u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .primary_mode,
    .switchover_cfg, .power_up_timer_done, .sleep_req, .wake, .pri_clk_pin(pri), .sec_clk_pin(sec),
    .int_clk_pin(intc), .sec_ready_pin(srdy), .sys_clk, .sec_osc_en, .osc_power_en,
    .active_src);
  cks_osc_model u_osc (.sec_en(sec_osc_en), .pri_clk(pri), .sec_clk(sec), .int_clk(intc),
    .sec_rdy(srdy));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic timed_out();
    miscompares++;
    $display("mismatch %0t wait limit reached", $time);
    end_sim();
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) timed_out();
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {20'h0_0000, a};
    wait_rdy();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wait_src(input logic [1:0] s);
    last_wait = 0;
    while (active_src !== s && last_wait < 3000) begin
      @(posedge hclk);
      last_wait++;
    end
    if (last_wait >= 3000) timed_out();
  endtask
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, OSC_STAT_OFS, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 200);
    if (n >= 200) timed_out();
  endtask
  task automatic pulse(input logic s);
    if (s) sleep_req <= 1'b1;
    else wake <= 1'b1;
    @(posedge hclk);
    sleep_req <= 1'b0;
    wake      <= 1'b0;
    @(posedge hclk);
  endtask
  initial begin
    {hresetn, hsel, hwrite, sleep_req, wake, power_up_timer_done} <= 6'h00;
    {haddr, hwdata, htrans} <= 66'h0;
    primary_mode   <= MODE_HS;
    switchover_cfg <= 1'b1;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    power_up_timer_done <= 1'b1;
    repeat (6) @(posedge hclk);
    bus(1'b0, OSC_CTRL_OFS, 32'h0);
    `CHK(rd, 32'h0000_0038)
    `CHK(active_src, 2'(ACT_INT))
    wait_src(ACT_PRI);
    bus(1'b0, OSC_STAT_OFS, 32'h0);
    `CHK(rd[STARTUP_TIMER_STATUS_FLAG_BIT], 1'b1)
    bus(1'b1, OSC_CTRL_OFS, 32'h0000_003C);
    bus(1'b0, OSC_CTRL_OFS, 32'h0);
    `CHK(rd, 32'h0000_0038)
    bus(1'b0, 12'h010, 32'h0);
    `CHK(rd, 32'h0)
    $display("test start-up done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OSC_CTRL_OFS, (32'(fs[i]) << IRCF_LSB) | 32'h2);
      wait_src(ACT_INT);
      poll(fb[i]);
      `CHK(rd & 32'h0000_0016, 32'h1 << fb[i])
      `CHK(osc_power_en[pb[i]], 1'b1)
    end
    $display("test internal switch done");
    bus(1'b1, TMR1_CTRL_OFS, 32'h0000_0008);
    repeat (2) @(posedge hclk);
    #1;
    `CHK(sec_osc_en, 1'b1)
    poll(SECONDARY_OSC_READY_FLAG_BIT);
    bus(1'b1, OSC_CTRL_OFS, 32'h0000_0039);
    wait_src(ACT_SEC);
    `CHK(active_src, 2'(ACT_SEC))
    $display("test secondary done");
    bus(1'b1, OSC_CTRL_OFS, 32'h0000_0038);
    wait_src(ACT_PRI);
    pulse(1'b1);
    pulse(1'b0);
    wait_src(ACT_INT);
    bus(1'b0, OSC_STAT_OFS, 32'h0);
    `CHK(rd[STARTUP_TIMER_STATUS_FLAG_BIT], 1'b0)
    pulse(1'b1);
    repeat (200) @(posedge hclk);
    bus(1'b0, OSC_STAT_OFS, 32'h0);
    `CHK(rd[STARTUP_TIMER_STATUS_FLAG_BIT], 1'b0)
    pulse(1'b0);
    wait_src(ACT_PRI);
    `CHK(last_wait >= 56, 1'b1)
    $display("test sleep abort done");
    primary_mode <= 3'h4;
    pulse(1'b1);
    pulse(1'b0);
    repeat (20) @(posedge hclk);
    `CHK(active_src, 2'(ACT_PRI))
    bus(1'b0, OSC_STAT_OFS, 32'h0);
    `CHK(rd[STARTUP_TIMER_STATUS_FLAG_BIT], 1'b1)
    $display("test non-crystal done");
    end_sim();
  end
endmodule
bind cks_top cks_top_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp, .primary_mode, .switchover_cfg, .sleep_req, .wake,
  .sys_clk, .sec_osc_en, .osc_power_en, .active_src);
